// file: hw/mpsc_consts.svh
/*
  Constants of the module power-state control block: clock rate, press
  width, warning lead time, reset stretch and idle levels of the pins.
  Assumes the clock runs at the rate given here.
*/
`ifndef MPSC_CONSTS_SVH
`define MPSC_CONSTS_SVH

`define MPSC_CLK_MHZ        125
`define MPSC_CLK_KHZ        125000

// Least press width on every button and event input
`define MPSC_PRESS_MIN_MS   16
`define MPSC_PRESS_MIN_CYC  (`MPSC_PRESS_MIN_MS * `MPSC_CLK_KHZ)

// Lead time of the suspend warning before the rails change
`define MPSC_WARN_NS        1000
`define MPSC_WARN_CYC       ((`MPSC_WARN_NS * `MPSC_CLK_MHZ + 999) / 1000)

// Width of the module reset pulse after a reset press
`define MPSC_RST_HOLD_MS    1
`define MPSC_RST_HOLD_CYC   (`MPSC_RST_HOLD_MS * `MPSC_CLK_KHZ)

// Idle level of the pulled-up active-low inputs
`define MPSC_IN_IDLE        1'b1
// Reset values of the active-low outputs (soft off after reset)
`define MPSC_SUSP_RST       1'b1
`define MPSC_RAIL_RST       1'b0
`define MPSC_SOFT_RST       1'b0
`define MPSC_MRST_RST       1'b1

`endif

// file: hw/mpsc_pkg.sv
/*
  Types of the module power-state control block.
  Assumes nothing of its surroundings.
*/
package mpsc_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON,
    ST_WARN,
    ST_S3,
    ST_S4
  } mpsc_state_e;

endpackage

// file: hw/mpsc_evt_if.sv
/*
  Carrier of one filtered input: its stable level and its edge pulses.
  Assumes a single clock shared by producer and consumer.
*/
interface mpsc_evt_if;
  logic level;
  logic fell;
  logic rose;

  modport src (output level, output fell, output rose);
  modport dst (input level, input fell, input rose);
endinterface

// file: hw/mpsc_debounce.sv
/*
  Two-flop synchroniser and debouncer for one active-low pin, with
  registered edge pulses of the filtered level.
  Assumes the pin idles high through its pull-up.
*/
`include "mpsc_consts.svh"

module mpsc_debounce #(
  parameter int unsigned CYC = `MPSC_PRESS_MIN_CYC
) (
  input  wire logic clk,  // Standby clock
  input  wire logic rst,  // Synchronous reset
  input  wire logic raw,  // Pin level
  mpsc_evt_if.src   ev    // Filtered level and edges
);
  localparam int CW = $clog2(CYC + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic          level_reg;
  logic          level_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          fell_reg;
  logic          fell_next;
  logic          rose_reg;
  logic          rose_next;

  // A change is taken only after CYC equal samples, so shorter pulses vanish
  always_comb begin
    level_next = level_reg;
    cnt_next   = '0;
    fell_next  = 1'b0;
    rose_next  = 1'b0;
    if (sync2_reg != level_reg) begin
      if (cnt_reg == CW'(CYC - 1)) begin
        level_next = sync2_reg;
        fell_next  = ~sync2_reg;
        rose_next  = sync2_reg;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= `MPSC_IN_IDLE;
      sync2_reg <= `MPSC_IN_IDLE;
      level_reg <= `MPSC_IN_IDLE;
      cnt_reg   <= '0;
      fell_reg  <= 1'b0;
      rose_reg  <= 1'b0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      level_reg <= level_next;
      cnt_reg   <= cnt_next;
      fell_reg  <= fell_next;
      rose_reg  <= rose_next;
    end
  end

  assign ev.level = level_reg;
  assign ev.fell  = fell_reg;
  assign ev.rose  = rose_reg;
endmodule

// file: hw/mpsc_timer.sv
/*
  Down-counter with load, busy level and a one-cycle done pulse.
  Assumes start is a single-cycle request; a new start reloads.
*/
module mpsc_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,   // Standby clock
  input  wire logic         rst,   // Synchronous reset
  input  wire logic         start, // Load request
  input  wire logic [W-1:0] load,  // Cycles to run
  output logic              busy,  // Counting
  output logic              done   // Pulse at the end
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         done_reg;
  logic         done_next;

  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = load;
    end else if (cnt_reg != '0) begin
      cnt_next  = cnt_reg - W'(1);
      done_next = (cnt_reg == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;
endmodule

// file: hw/mpsc_top.sv
/*
  Power-state control of the processor module at its carrier connector:
  filters the buttons and event pins, sequences the sleep states and
  drives the active-low state outputs that switch the carrier's rails.
  Assumes the carrier pulls the inputs up and that all pins are already
  synchronous to clk in timing terms; each is still passed through two flops.
*/
`include "mpsc_consts.svh"

module mpsc_top #(
  parameter int unsigned PRESS_MIN_CYC = `MPSC_PRESS_MIN_CYC,
  parameter int unsigned RST_HOLD_CYC  = `MPSC_RST_HOLD_CYC,
  parameter int unsigned WARN_CYC      = `MPSC_WARN_CYC
) (
  input  wire logic clk,                // Standby clock, 125 MHz
  input  wire logic rst,                // Synchronous reset
  input  wire logic supply_good_in,     // Carrier supply ready
  input  wire logic power_button_n,     // Power button
  input  wire logic reset_button_n,     // Reset button
  input  wire logic sleep_button_n,     // Sleep button
  input  wire logic cover_switch_n,     // Lid switch, low when closed
  input  wire logic battery_low_n,      // Battery low event
  input  wire logic wake_n,             // External wake event
  output logic      suspend_pending_n,  // Low-power entry warning
  output logic      standby_rail_off_n, // Low in S3, S4, S5
  output logic      soft_off_state_n,   // Low in S4, S5
  output logic      module_reset_n,     // Module reset
  output logic      system_running,     // In S0
  output logic      power_press_evt,    // Power press pulse
  output logic      sleep_press_evt,    // Sleep press pulse
  output logic      cover_change_evt,   // Lid change pulse
  output logic      cover_closed,       // Filtered lid level
  output logic      battery_low_evt,    // Battery low pulse
  output logic      battery_low,        // Filtered battery low level
  output logic      wake_evt            // Wake request pulse
);
  localparam int NUM_IN  = 6;
  localparam int I_PWR   = 0;
  localparam int I_RST   = 1;
  localparam int I_SLP   = 2;
  localparam int I_CVR   = 3;
  localparam int I_BAT   = 4;
  localparam int I_WAKE  = 5;
  localparam int WARN_W  = $clog2(WARN_CYC + 1);
  localparam int HOLD_W  = $clog2(RST_HOLD_CYC + 1);

  // Bit order follows the I_ indices above
  logic [NUM_IN-1:0] raw_n;

  assign raw_n = {wake_n, battery_low_n, cover_switch_n,
                  sleep_button_n, reset_button_n, power_button_n};

  // One carrier per pin between its filter and the sequencer
  mpsc_evt_if evt [NUM_IN] ();

  // Every button and event pin gets the same filter; the press width is the one figure
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_deb
      mpsc_debounce #(
        .CYC (PRESS_MIN_CYC)
      ) u_deb (
        .clk (clk),
        .rst (rst),
        .raw (raw_n[gi]),
        .ev  (evt[gi])
      );
    end
  endgenerate

  logic pwr_fell;
  logic rst_fell;
  logic slp_fell;
  logic cvr_fell;
  logic cvr_rose;
  logic cvr_level;
  logic bat_fell;
  logic bat_level;
  logic wake_fell;

  assign pwr_fell  = evt[I_PWR].fell;
  assign rst_fell  = evt[I_RST].fell;
  assign slp_fell  = evt[I_SLP].fell;
  assign cvr_fell  = evt[I_CVR].fell;
  assign cvr_rose  = evt[I_CVR].rose;
  assign cvr_level = evt[I_CVR].level;
  assign bat_fell  = evt[I_BAT].fell;
  assign bat_level = evt[I_BAT].level;
  assign wake_fell = evt[I_WAKE].fell;

  // Supply-good level, two flops; it is a level, so no debounce
  // Resets low so the block sits in soft off until the carrier is ready
  logic sg_sync1_reg;
  logic sg_sync2_reg;
  logic supply_ok;

  always_ff @(posedge clk) begin
    if (rst) begin
      sg_sync1_reg <= 1'b0;
      sg_sync2_reg <= 1'b0;
    end else begin
      sg_sync1_reg <= supply_good_in;
      sg_sync2_reg <= sg_sync1_reg;
    end
  end

  assign supply_ok = sg_sync2_reg;

  // Power-state sequencer
  mpsc_pkg::mpsc_state_e state_reg;
  mpsc_pkg::mpsc_state_e state_next;
  mpsc_pkg::mpsc_state_e target_reg;
  mpsc_pkg::mpsc_state_e target_next;
  logic                  warn_start;
  logic                  warn_done;
  logic                  reset_req;

  // In soft off nothing runs that could be reset, so the press is dropped
  assign reset_req = rst_fell & supply_ok &
                     (state_reg != mpsc_pkg::ST_OFF);

  always_comb begin
    state_next  = state_reg;
    target_next = target_reg;
    warn_start  = 1'b0;
    if (!supply_ok) begin
      // Losing the supply drops straight to soft off, no warning possible
      state_next = mpsc_pkg::ST_OFF;
    end else if (reset_req) begin
      state_next = mpsc_pkg::ST_ON;
    end else begin
      unique case (state_reg)
        mpsc_pkg::ST_OFF: begin
          if (pwr_fell || wake_fell) begin
            state_next = mpsc_pkg::ST_ON;
          end
        end
        mpsc_pkg::ST_ON: begin
          // Power outranks battery low, which outranks sleep and lid
          if (pwr_fell) begin
            target_next = mpsc_pkg::ST_OFF;
            state_next  = mpsc_pkg::ST_WARN;
            warn_start  = 1'b1;
          end else if (bat_fell) begin
            target_next = mpsc_pkg::ST_S4;
            state_next  = mpsc_pkg::ST_WARN;
            warn_start  = 1'b1;
          end else if (slp_fell || cvr_fell) begin
            target_next = mpsc_pkg::ST_S3;
            state_next  = mpsc_pkg::ST_WARN;
            warn_start  = 1'b1;
          end
        end
        mpsc_pkg::ST_WARN: begin
          // Presses during the warning are dropped; only reset or supply loss cut it
          if (warn_done) begin
            state_next = target_reg;
          end
        end
        mpsc_pkg::ST_S3: begin
          // Lid open wakes only from sleep; in S0 it is just reported
          if (pwr_fell || slp_fell || cvr_rose || wake_fell) begin
            state_next = mpsc_pkg::ST_ON;
          end
        end
        mpsc_pkg::ST_S4: begin
          if (pwr_fell || wake_fell) begin
            state_next = mpsc_pkg::ST_ON;
          end
        end
        default: begin
          state_next = mpsc_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= mpsc_pkg::ST_OFF;
      target_reg <= mpsc_pkg::ST_OFF;
    end else begin
      state_reg  <= state_next;
      target_reg <= target_next;
    end
  end

  // Warning lead time; the rails move once it has run out, or at once on a supply loss
  mpsc_timer #(
    .W (WARN_W)
  ) u_warn (
    .clk   (clk),
    .rst   (rst),
    .start (warn_start),
    .load  (WARN_W'(WARN_CYC)),
    .busy  (),
    .done  (warn_done)
  );

  // Module reset stretch; a second press restarts the pulse
  // The stretch runs on through a supply drop, so the carrier sees a full pulse
  logic hold_busy;

  mpsc_timer #(
    .W (HOLD_W)
  ) u_hold (
    .clk   (clk),
    .rst   (rst),
    .start (reset_req),
    .load  (HOLD_W'(RST_HOLD_CYC)),
    .busy  (hold_busy),
    .done  ()
  );

  // State outputs, registered from the next state so they track it exactly
  // Registering costs no latency here and keeps the carrier's pins glitch-free
  logic susp_reg;
  logic susp_next;
  logic rail_reg;
  logic rail_next;
  logic soft_reg;
  logic soft_next;
  logic mrst_reg;
  logic mrst_next;
  logic run_reg;
  logic run_next;

  always_comb begin
    susp_next = ~(state_next == mpsc_pkg::ST_WARN);
    rail_next = ~(state_next == mpsc_pkg::ST_S3 ||
                  state_next == mpsc_pkg::ST_S4 ||
                  state_next == mpsc_pkg::ST_OFF);
    soft_next = ~(state_next == mpsc_pkg::ST_S4 ||
                  state_next == mpsc_pkg::ST_OFF);
    mrst_next = ~(reset_req | hold_busy);
    run_next  = (state_next == mpsc_pkg::ST_ON);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      susp_reg <= `MPSC_SUSP_RST;
      rail_reg <= `MPSC_RAIL_RST;
      soft_reg <= `MPSC_SOFT_RST;
      mrst_reg <= `MPSC_MRST_RST;
      run_reg  <= 1'b0;
    end else begin
      susp_reg <= susp_next;
      rail_reg <= rail_next;
      soft_reg <= soft_next;
      mrst_reg <= mrst_next;
      run_reg  <= run_next;
    end
  end

  // Event reports; with no supply nobody listens, so they are masked
  // Levels stay unmasked so the pins can be read even with the supply down
  logic [4:0] ev_reg;
  logic [4:0] ev_next;
  logic [1:0] lvl_reg;
  logic [1:0] lvl_next;

  always_comb begin
    ev_next[0] = supply_ok & pwr_fell;
    ev_next[1] = supply_ok & slp_fell;
    ev_next[2] = supply_ok & (cvr_fell | cvr_rose);
    ev_next[3] = supply_ok & bat_fell;
    ev_next[4] = supply_ok & wake_fell;
    lvl_next   = {~bat_level, ~cvr_level};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      ev_reg  <= ev_next;
      lvl_reg <= lvl_next;
    end
  end

  assign suspend_pending_n  = susp_reg;
  assign standby_rail_off_n = rail_reg;
  assign soft_off_state_n   = soft_reg;
  assign module_reset_n     = mrst_reg;
  assign system_running     = run_reg;
  assign power_press_evt    = ev_reg[0];
  assign sleep_press_evt    = ev_reg[1];
  assign cover_change_evt   = ev_reg[2];
  assign battery_low_evt    = ev_reg[3];
  assign wake_evt           = ev_reg[4];
  assign cover_closed       = lvl_reg[0];
  assign battery_low        = lvl_reg[1];
endmodule

// file: sim/mpsc_top_asserts.sv
/*
  Port checker of the power-state control top.
  Assumes one clock and a synchronous active-high reset.
*/
module mpsc_top_asserts #(
  parameter int unsigned PRESS_MIN_CYC = 4,
  parameter int unsigned RST_HOLD_CYC  = 8,
  parameter int unsigned WARN_CYC      = 5
) (
  input wire logic clk,                // Standby clock
  input wire logic rst,                // Synchronous reset
  input wire logic supply_good_in,     // Supply ready
  input wire logic suspend_pending_n,  // Entry warning
  input wire logic standby_rail_off_n, // Rails off
  input wire logic soft_off_state_n,   // Soft off
  input wire logic module_reset_n,     // Module reset
  input wire logic system_running,     // In S0
  input wire logic power_press_evt,    // Power press
  input wire logic sleep_press_evt,    // Sleep press
  input wire logic battery_low_evt,    // Battery low
  input wire logic wake_evt            // Wake request
);
  logic [3:0]  sup_reg, sup_next;
  logic [31:0] warn_reg, warn_next;
  logic [31:0] hold_reg, hold_next;
  logic        sup_ok;

  // Supply must have been steady long enough to pass the design's synchroniser
  assign sup_ok = (sup_reg >= 4'h4);

  always_comb begin
    sup_next  = supply_good_in ? ((sup_reg == 4'hF) ? sup_reg : sup_reg + 4'h1) : 4'h0;
    warn_next = suspend_pending_n ? 32'h0 : warn_reg + 32'h1;
    hold_next = module_reset_n ? 32'h0 : hold_reg + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sup_reg  <= 4'h0;
      warn_reg <= 32'h0;
      hold_reg <= 32'h0;
    end else begin
      sup_reg  <= sup_next;
      warn_reg <= warn_next;
      hold_reg <= hold_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence warn_entry;
    (power_press_evt || sleep_press_evt || battery_low_evt) && $past(system_running)
      && module_reset_n && sup_ok;
  endsequence

  sequence wake_entry;
    (power_press_evt || wake_evt) && $past(!soft_off_state_n) && $past(suspend_pending_n)
      && module_reset_n && sup_ok;
  endsequence

  AST_WARN_ENTRY: assert property (warn_entry |-> !suspend_pending_n && !system_running)
    else $error("no warning after a press in S0");
  AST_WAKE: assert property (wake_entry |-> system_running)
    else $error("no return to S0 from off");
  AST_WARN_LEN: assert property ($rose(suspend_pending_n) && module_reset_n && sup_ok
    |-> warn_reg == WARN_CYC + 1) else $error("warning width wrong");
  AST_WARN_LEVELS: assert property (!suspend_pending_n
    |-> standby_rail_off_n && soft_off_state_n && !system_running)
    else $error("rails changed during warning");
  AST_SOFT_RAIL: assert property (!soft_off_state_n |-> !standby_rail_off_n && !system_running)
    else $error("soft off without rails off");
  AST_RUN_RAILS: assert property (system_running |-> standby_rail_off_n && soft_off_state_n)
    else $error("rails off while running");
  AST_SUPPLY_LOSS: assert property ($fell(supply_good_in)
    |-> ##[1:4] (!soft_off_state_n && !standby_rail_off_n)) else $error("supply loss not off");
  AST_RST_LEN: assert property ($rose(module_reset_n) && sup_ok
    |-> hold_reg == RST_HOLD_CYC + 1) else $error("module reset width wrong");
  AST_RST_ON: assert property ($fell(module_reset_n) |-> system_running)
    else $error("module reset not in S0");
  AST_EVT_ONE: assert property (power_press_evt |=> !power_press_evt [*3])
    else $error("power press repeated");
endmodule

bind mpsc_top mpsc_top_asserts #(
  .PRESS_MIN_CYC(PRESS_MIN_CYC),
  .RST_HOLD_CYC (RST_HOLD_CYC),
  .WARN_CYC     (WARN_CYC)
) i_asserts (
  .clk               (clk),
  .rst               (rst),
  .supply_good_in    (supply_good_in),
  .suspend_pending_n (suspend_pending_n),
  .standby_rail_off_n(standby_rail_off_n),
  .soft_off_state_n  (soft_off_state_n),
  .module_reset_n    (module_reset_n),
  .system_running    (system_running),
  .power_press_evt   (power_press_evt),
  .sleep_press_evt   (sleep_press_evt),
  .battery_low_evt   (battery_low_evt),
  .wake_evt          (wake_evt)
);

// file: sim/mpsc_carrier.sv
/*
  Carrier-board model: supply monitor and pulled-up buttons.
  Assumes the bench calls its tasks just after a rising edge.
*/
module mpsc_carrier (
  input  wire logic  clk,            // Standby clock
  output logic       supply_good_in, // Supply ready
  output logic [5:0] pin_n           // Power, reset, sleep, cover, battery, wake
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    supply_good_in = 1'b0;
    pin_n          = 6'h3F;
  end

  // A released pin returns to its pull-up level, never floats
  task automatic drive(input int idx, input logic val, input int cyc);
    pin_n[idx] = val;
    repeat (cyc) @(posedge clk);
    #1;
  endtask

  task automatic set_supply(input logic val);
    supply_good_in = val;
  endtask
endmodule

// file: sim/tb_mpsc_top.sv
/*
  Self-checking bench of the power-state control top.
  Assumes short press, hold and warning counts set at instantiation.
*/
module tb_mpsc_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned PRESS = 4;
  localparam int unsigned HOLD  = 8;
  localparam int unsigned WARN  = 5;

  logic       clk, rst, supply_good_in, susp_n, rail_n, soft_n, mrst_n, running;
  logic       pwr_e, slp_e, cov_e, bat_e, wk_e, cover_closed, battery_low;
  logic [5:0] pin_n;
  int         err_total, checked, warn_cyc;
  int         evt[6];

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  mpsc_carrier i_car (.clk(clk), .supply_good_in(supply_good_in), .pin_n(pin_n));

  mpsc_top #(.PRESS_MIN_CYC(PRESS), .RST_HOLD_CYC(HOLD), .WARN_CYC(WARN)) i_dut (
    .clk(clk), .rst(rst), .supply_good_in(supply_good_in),
    .power_button_n(pin_n[0]), .reset_button_n(pin_n[1]), .sleep_button_n(pin_n[2]),
    .cover_switch_n(pin_n[3]), .battery_low_n(pin_n[4]), .wake_n(pin_n[5]),
    .suspend_pending_n(susp_n), .standby_rail_off_n(rail_n), .soft_off_state_n(soft_n),
    .module_reset_n(mrst_n), .system_running(running), .power_press_evt(pwr_e),
    .sleep_press_evt(slp_e), .cover_change_evt(cov_e), .cover_closed(cover_closed),
    .battery_low_evt(bat_e), .battery_low(battery_low), .wake_evt(wk_e));

  always @(posedge clk) begin
    if (pwr_e === 1'b1) evt[0]++;
    if (mrst_n === 1'b0) evt[1]++;
    if (slp_e === 1'b1) evt[2]++;
    if (cov_e === 1'b1) evt[3]++;
    if (bat_e === 1'b1) evt[4]++;
    if (wk_e === 1'b1) evt[5]++;
    if (susp_n === 1'b0) warn_cyc++;
  end

  task automatic report_and_stop;
    $display("counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_num(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  // State word is {running, suspend_pending_n, standby_rail_off_n, soft_off_state_n}
  task automatic chk_state(input logic [3:0] exp, input string what);
    checked++;
    if ({running, susp_n, rail_n, soft_n} !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s state %b", $time, what, {running, susp_n, rail_n, soft_n});
    end
  endtask

  // Settle covers filter latency, warning and release debounce
  task automatic press(input int idx, input int cyc);
    i_car.drive(idx, 1'b0, cyc);
    i_car.drive(idx, 1'b1, 24);
  endtask

  // Press followed by checks of event count, warning width and the state reached (which may be unchanged)
  task automatic step(input int idx, input int n_evt, input int n_warn, input logic [3:0] st,
                      input string what);
    int e, w;
    e = evt[idx];
    w = warn_cyc;
    press(idx, PRESS + 2);
    chk_num(evt[idx] - e, n_evt, what);
    chk_num(warn_cyc - w, n_warn, what);
    chk_state(st, what);
    $display("step %s done", what);
  endtask

  task automatic wait_running;
    int n;
    for (n = 0; n < 50 && running !== 1'b1; n++) @(posedge clk);
    #1;
    if (running !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t timeout waiting for S0", $time);
      report_and_stop();
    end
  endtask

  task automatic t_glitch;
    int e;
    e = evt[0];
    press(0, PRESS - 1);
    chk_num(evt[0] - e, 0, "short press");
    chk_state(4'hF, "short press");
    $display("test glitch done");
  endtask

  task automatic t_cover;
    int e;
    e = evt[3];
    i_car.drive(3, 1'b0, 30);
    chk_num(int'(cover_closed === 1'b1), 1, "lid closed");
    chk_state(4'h5, "lid closed");
    i_car.drive(3, 1'b1, 30);
    chk_state(4'hF, "lid open");
    chk_num(int'(cover_closed === 1'b0), 1, "lid open level");
    chk_num(evt[3] - e, 2, "lid events");
    $display("test cover done");
  endtask

  task automatic t_supply;
    int w;
    w = warn_cyc;
    i_car.set_supply(1'b0);
    repeat (6) @(posedge clk);
    #1;
    chk_state(4'h4, "supply lost");
    chk_num(warn_cyc - w, 0, "supply lost");
    step(0, 0, 0, 4'h4, "press without supply");
    i_car.set_supply(1'b1);
    repeat (6) @(posedge clk);
    #1;
    press(0, PRESS + 2);
    wait_running();
    chk_state(4'hF, "supply back");
    $display("test supply done");
  endtask

  task automatic t_power_on;
    step(0, 1, 0, 4'hF, "power on");
    $display("test power on done");
  endtask

  task automatic t_sleep;
    step(2, 1, WARN + 1, 4'h5, "sleep");
    step(2, 1, 0, 4'hF, "wake by sleep");
    step(2, 1, WARN + 1, 4'h5, "sleep twice");
    step(5, 1, 0, 4'hF, "wake from S3");
    $display("test sleep done");
  endtask

  task automatic t_reset;
    step(2, 1, WARN + 1, 4'h5, "sleep again");
    step(1, HOLD + 1, 0, 4'hF, "reset press");
    $display("test reset done");
  endtask

  task automatic t_battery;
    int e, w;
    e = evt[4];
    w = warn_cyc;
    i_car.drive(4, 1'b0, 30);
    chk_num(int'(battery_low === 1'b1), 1, "battery low level");
    chk_state(4'h4, "battery low");
    i_car.drive(4, 1'b1, 30);
    chk_num(int'(battery_low === 1'b0), 1, "battery level clear");
    chk_num(evt[4] - e, 1, "battery events");
    chk_num(warn_cyc - w, WARN + 1, "battery warning");
    step(0, 1, 0, 4'hF, "power from S4");
    $display("test battery done");
  endtask

  task automatic t_power_off;
    step(0, 1, WARN + 1, 4'h4, "power off");
    step(1, 0, 0, 4'h4, "reset in off");
    step(5, 1, 0, 4'hF, "wake from off");
    $display("test power off done");
  endtask

  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    chk_state(4'h4, "after reset");
    i_car.set_supply(1'b1);
    repeat (6) @(posedge clk);
    #1;
    t_power_on();
    t_glitch();
    t_sleep();
    t_cover();
    t_reset();
    t_battery();
    t_power_off();
    t_supply();
    report_and_stop();
  end
endmodule
